// >>> design/fawp_pkg.sv
// Package: constants and types for the flash array write protection block
package fawp_pkg;
    // ------------------------------------------------------------
    // Array geometry (smallest density, 256 KB sectors)
    // ------------------------------------------------------------
    localparam int SECTOR_COUNT = 128;
    localparam int SECTOR_BITS = 7;
    localparam int ADDR_BITS = 25;
    localparam int ARRAY_KB = 32768;
    localparam int SIXTY_FOURTH_KB = 512;
    // ------------------------------------------------------------
    // APB register offsets (byte addresses)
    // ------------------------------------------------------------
    localparam logic [7:0] OFS_STATUS_ONE_V = 8'h00;
    localparam logic [7:0] OFS_STATUS_ONE_NV = 8'h04;
    localparam logic [7:0] OFS_CONFIG_ONE_V = 8'h08;
    localparam logic [7:0] OFS_CONFIG_ONE_NV = 8'h0c;
    localparam logic [7:0] OFS_COMMAND = 8'h10;
    localparam logic [7:0] OFS_GUARD_SELECT = 8'h14;
    localparam logic [7:0] OFS_GUARD_DATA = 8'h18;
    localparam logic [7:0] OFS_REQUEST = 8'h1c;
    localparam logic [7:0] OFS_RESULT = 8'h20;
    localparam logic [7:0] OFS_SCHEME = 8'h24;
    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int WRITE_ENABLE_POS = 1;
    localparam int LEVEL_LSB = 2;
    localparam int LEVEL_MSB = 4;
    localparam int STATUS_WRITE_DISABLE_POS = 7;
    localparam int TEMP_LOCK_POS = 0;
    localparam int SMALL_TB_POS = 2;
    localparam int PERM_LOCK_POS = 4;
    localparam int TOP_BOTTOM_POS = 5;
    localparam int SMALL_SPLIT_POS = 6;
    localparam int REQ_ERASE_POS = 31;
    localparam int VOL_GUARD_POS = 0;
    localparam int PERS_GUARD_POS = 1;
    // ------------------------------------------------------------
    // Reset values and masks
    // ------------------------------------------------------------
    localparam logic [7:0] STATUS_RESET = 8'h00;
    localparam logic [7:0] CONFIG_RESET = 8'h00;
    localparam logic [7:0] CONFIG_LOCKED_MASK = 8'h75;
    localparam logic [7:0] STATUS_LOCKED_MASK = 8'h1c;
    // ------------------------------------------------------------
    // Commands written to the command register
    // ------------------------------------------------------------
    typedef enum logic [3:0] {
        CMD_NONE = 4'h0,
        CMD_WRITE_ENABLE = 4'h1,
        CMD_WRITE_DISABLE = 4'h2,
        CMD_VOL_GUARD_WRITE = 4'h3,
        CMD_PERS_GUARD_PROGRAM = 4'h4,
        CMD_PERS_GUARD_ERASE_ALL = 4'h5,
        CMD_GUARD_LOCK = 4'h6,
        CMD_CHIP_SELECT_RESET = 4'h7,
        CMD_NV_CONFIG_LOCK = 4'h8
    } fawp_cmd_type;
endpackage

// >>> design/fawp_guard_if.sv
// Interface: per-sector guard memory port
`timescale 1ns/1ps
interface fawp_guard_if;
    import fawp_pkg::*;
    logic [SECTOR_BITS-1:0] addr;
    logic write_en;
    logic clear_all_pers;
    logic set_all_vol;
    logic [1:0] wdata;
    logic [1:0] rdata;
    logic [SECTOR_BITS-1:0] check_addr;
    logic [1:0] check_bits;
    modport ctrl (output addr, write_en, clear_all_pers, set_all_vol,
        wdata, check_addr, input rdata, check_bits);
    modport mem (input addr, write_en, clear_all_pers, set_all_vol,
        wdata, check_addr, output rdata, check_bits);
endinterface

// >>> design/fawp_guard_mem.sv
// Memory of per-sector volatile and persistent guard bit pairs
`timescale 1ns/1ps
module fawp_guard_mem (
    input wire logic pclk,
    input wire logic presetn,
    fawp_guard_if.mem port
);
    import fawp_pkg::*;
    // Bit 0 volatile, bit 1 persistent; 1 means unprotected
    logic [SECTOR_COUNT-1:0] vol_guard;
    logic [SECTOR_COUNT-1:0] pers_guard;
    logic [SECTOR_COUNT-1:0] next_vol_guard;
    logic [SECTOR_COUNT-1:0] next_pers_guard;
    logic [1:0] rdata;
    logic [1:0] check_bits;
    logic [1:0] next_rdata;
    logic [1:0] next_check_bits;

    always_comb begin
        next_vol_guard = vol_guard;
        next_pers_guard = pers_guard;
        if (port.set_all_vol) begin
            next_vol_guard = '1;
        end
        if (port.clear_all_pers) begin
            next_pers_guard = '1;
        end
        if (port.write_en) begin
            next_vol_guard[port.addr] = port.wdata[VOL_GUARD_POS];
            next_pers_guard[port.addr] = port.wdata[PERS_GUARD_POS];
        end
        next_rdata = {pers_guard[port.addr], vol_guard[port.addr]};
        next_check_bits = {pers_guard[port.check_addr],
            vol_guard[port.check_addr]};
    end

    // Persistent bits power up unprotected here; a real part keeps them
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            vol_guard <= '1;
            pers_guard <= '1;
            rdata <= 2'h3;
            check_bits <= 2'h3;
        end else begin
            vol_guard <= next_vol_guard;
            pers_guard <= next_pers_guard;
            rdata <= next_rdata;
            check_bits <= next_check_bits;
        end
    end

    assign port.rdata = rdata;
    assign port.check_bits = check_bits;
endmodule // fawp_guard_mem

// >>> design/fawp_top.sv
// Top: flash array write protection with APB register access
//
// Contract
// - Protected region comes from level field and top/bottom select bit.
// - Select 0 protects from highest address, 1 from lowest address.
// - Levels protect none, 1/64 ... 1/2, whole array in order.
// - Both lock bits 0 leaves status and config registers writable.
// - Permanent lock blocks protection field changes regardless of temp lock.
// - Temporary lock blocks changes until power-down or any reset.
// - Locked configuration keeps selected array blocks protected.
// - Protect pin low with write-disable set blocks status/config writes.
// - Register read, register write and write-enable transactions are served.
// - Each sector has one volatile and one persistent guard bit.
// - Guard bit 0 protects its sector, 1 unprotects.
// - Volatile guards change freely; persistent guards limited by endurance.
// - Persistent guard configuration can be locked against changes.
// - Volatile guard matters only when persistent guard is 1.
// - Guard lock is 1 after reset; once cleared software cannot set it.
`timescale 1ns/1ps
module fawp_top (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic write_protect_input_n,
    output logic request_granted,
    output logic request_refused
);
    import fawp_pkg::*;

    fawp_guard_if guard_port ();

    fawp_guard_mem u_guard_mem (
        .pclk(pclk),
        .presetn(presetn),
        .port(guard_port)
    );

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    logic [7:0] status_one_volatile;
    logic [7:0] status_one_nonvolatile;
    logic [7:0] config_one_volatile;
    logic [7:0] config_one_nonvolatile;
    logic [SECTOR_BITS-1:0] guard_select;
    logic persistent_guard_lock_bit;
    logic nv_config_locked;
    logic per_sector_scheme;
    logic req_pending;
    logic req_erase;
    logic [ADDR_BITS-1:0] req_addr;
    logic [7:0] next_status_v;
    logic [7:0] next_status_nv;
    logic [7:0] next_config_v;
    logic [7:0] next_config_nv;
    logic [SECTOR_BITS-1:0] next_guard_select;
    logic next_guard_lock;
    logic next_nv_locked;
    logic next_scheme;
    logic next_req_pending;
    logic next_req_erase;
    logic [ADDR_BITS-1:0] next_req_addr;
    logic [31:0] next_prdata;
    logic next_pready;
    logic next_pslverr;
    logic next_granted;
    logic next_refused;

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    // Size of the protected block in 64ths of the array
    function automatic logic [6:0] block_64ths(input logic [2:0] level);
        logic [6:0] size;
        size = 7'h00;
        if (level == 3'h7) begin
            size = 7'h40;
        end else if (level != 3'h0) begin
            size = 7'(7'h01 << (level - 3'h1));
        end
        return size;
    endfunction

    function automatic logic in_block(input logic [2:0] level,
        input logic bottom, input logic [ADDR_BITS-1:0] addr);
        logic [6:0] slice;
        logic [6:0] size;
        logic hit;
        slice = {1'b0, addr[ADDR_BITS-1:ADDR_BITS-6]};
        size = block_64ths(level);
        if (bottom) begin
            hit = slice < size;
        end else begin
            hit = (7'h40 - slice) <= size;
        end
        return hit;
    endfunction

    // ------------------------------------------------------------
    // Derived protection state
    // ------------------------------------------------------------
    logic write_enabled;
    logic config_locked;
    logic pin_locked;
    logic legacy_hit;
    logic sector_guarded;
    logic apb_access;
    logic apb_wr;
    logic [7:0] wr_byte;
    fawp_cmd_type cmd;

    assign write_enabled = status_one_volatile[WRITE_ENABLE_POS];
    // protection fields frozen by either lock bit
    assign config_locked = config_one_volatile[PERM_LOCK_POS]
        | config_one_volatile[TEMP_LOCK_POS];
    assign pin_locked = !write_protect_input_n
        && status_one_volatile[STATUS_WRITE_DISABLE_POS];
    assign legacy_hit = in_block(
        status_one_volatile[LEVEL_MSB:LEVEL_LSB],
        config_one_volatile[TOP_BOTTOM_POS], req_addr);
    // Persistent 0 protects outright, else volatile decides
    assign sector_guarded = per_sector_scheme
        && (!guard_port.check_bits[PERS_GUARD_POS]
        || !guard_port.check_bits[VOL_GUARD_POS]);
    assign apb_access = psel && penable && !pready;
    assign apb_wr = apb_access && pwrite;
    assign wr_byte = pwdata[7:0];
    assign cmd = fawp_cmd_type'(pwdata[3:0]);

    // Merge a write into a register, keeping locked bits
    function automatic logic [7:0] merge_locked(input logic [7:0] old,
        input logic [7:0] data, input logic [7:0] mask,
        input logic locked);
        return locked ? ((old & mask) | (data & ~mask)) : data;
    endfunction

    // ------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------
    always_comb begin
        next_status_v = status_one_volatile;
        next_status_nv = status_one_nonvolatile;
        next_config_v = config_one_volatile;
        next_config_nv = config_one_nonvolatile;
        next_guard_select = guard_select;
        next_guard_lock = persistent_guard_lock_bit;
        next_nv_locked = nv_config_locked;
        next_scheme = per_sector_scheme;
        next_req_pending = 1'b0;
        next_req_erase = req_erase;
        next_req_addr = req_addr;
        next_prdata = 32'h0000_0000;
        next_pready = 1'b0;
        next_pslverr = 1'b0;
        next_granted = 1'b0;
        next_refused = 1'b0;
        guard_port.addr = guard_select;
        guard_port.write_en = 1'b0;
        guard_port.clear_all_pers = 1'b0;
        guard_port.set_all_vol = 1'b0;
        guard_port.wdata = guard_port.rdata;

        // Request decision one cycle after capture so guard bits settle
        if (req_pending) begin
            if (legacy_hit || sector_guarded || !write_enabled) begin
                next_refused = 1'b1;
            end else begin
                next_granted = 1'b1;
            end
            next_status_v[WRITE_ENABLE_POS] = 1'b0;
        end

        if (apb_access) begin
            next_pready = 1'b1;
            case (paddr[7:0])
                OFS_STATUS_ONE_V: begin
                    next_prdata = {24'h000000, status_one_volatile};
                    if (apb_wr && write_enabled && !pin_locked) begin
                        next_status_v = merge_locked(status_one_volatile,
                            wr_byte, STATUS_LOCKED_MASK, config_locked);
                        next_status_v[WRITE_ENABLE_POS] = 1'b0;
                    end
                end
                OFS_STATUS_ONE_NV: begin
                    next_prdata = {24'h000000, status_one_nonvolatile};
                    if (apb_wr && write_enabled && !pin_locked) begin
                        next_status_nv = merge_locked(status_one_nonvolatile,
                            wr_byte, STATUS_LOCKED_MASK, config_locked);
                        next_status_v[WRITE_ENABLE_POS] = 1'b0;
                    end
                end
                OFS_CONFIG_ONE_V: begin
                    next_prdata = {24'h000000, config_one_volatile};
                    if (apb_wr && write_enabled && !pin_locked) begin
                        next_config_v = merge_locked(config_one_volatile,
                            wr_byte, CONFIG_LOCKED_MASK, config_locked);
                        // A write here only ever sets lock bits, never clears them
                        next_config_v[PERM_LOCK_POS] =
                            config_one_volatile[PERM_LOCK_POS]
                            | wr_byte[PERM_LOCK_POS];
                        next_config_v[TEMP_LOCK_POS] =
                            config_one_volatile[TEMP_LOCK_POS]
                            | wr_byte[TEMP_LOCK_POS];
                        next_status_v[WRITE_ENABLE_POS] = 1'b0;
                    end
                end
                OFS_CONFIG_ONE_NV: begin
                    next_prdata = {24'h000000, config_one_nonvolatile};
                    if (apb_wr && write_enabled && !pin_locked) begin
                        next_config_nv = merge_locked(config_one_nonvolatile,
                            wr_byte, CONFIG_LOCKED_MASK,
                            config_one_nonvolatile[PERM_LOCK_POS]
                            | config_locked);
                        next_status_v[WRITE_ENABLE_POS] = 1'b0;
                    end
                end
                OFS_COMMAND: begin
                    next_prdata = {30'h0, nv_config_locked,
                        persistent_guard_lock_bit};
                    if (apb_wr) begin
                        case (cmd)
                            CMD_WRITE_ENABLE:
                                next_status_v[WRITE_ENABLE_POS] = 1'b1;
                            CMD_WRITE_DISABLE:
                                next_status_v[WRITE_ENABLE_POS] = 1'b0;
                            CMD_VOL_GUARD_WRITE: begin
                                guard_port.write_en = 1'b1;
                                guard_port.wdata[VOL_GUARD_POS] = pwdata[8];
                            end
                            CMD_PERS_GUARD_PROGRAM: begin
                                if (persistent_guard_lock_bit
                                    && !nv_config_locked && write_enabled) begin
                                    guard_port.write_en = 1'b1;
                                    guard_port.wdata[PERS_GUARD_POS] =
                                        1'b0;
                                    next_status_v[WRITE_ENABLE_POS] = 1'b0;
                                end
                            end
                            CMD_PERS_GUARD_ERASE_ALL: begin
                                if (persistent_guard_lock_bit
                                    && !nv_config_locked && write_enabled) begin
                                    guard_port.clear_all_pers = 1'b1;
                                    next_status_v[WRITE_ENABLE_POS] = 1'b0;
                                end
                            end
                            CMD_GUARD_LOCK:
                                next_guard_lock = 1'b0;
                            CMD_NV_CONFIG_LOCK:
                                next_nv_locked = 1'b1;
                            CMD_CHIP_SELECT_RESET: begin
                                // Reloads volatile status and config from nonvolatile, clears the temporary lock and sets all volatile guards
                                next_config_v = config_one_nonvolatile;
                                next_config_v[TEMP_LOCK_POS] = 1'b0;
                                next_status_v = status_one_nonvolatile;
                                next_status_v[WRITE_ENABLE_POS] = 1'b0;
                                guard_port.set_all_vol = 1'b1;
                            end
                            default: ;
                        endcase
                    end
                end
                OFS_GUARD_SELECT: begin
                    next_prdata = {25'h0, guard_select};
                    if (apb_wr) begin
                        next_guard_select = pwdata[SECTOR_BITS-1:0];
                    end
                end
                OFS_GUARD_DATA: begin
                    next_prdata = {30'h0, guard_port.rdata};
                end
                OFS_REQUEST: begin
                    next_prdata = {req_erase, 6'h00, req_addr};
                    if (apb_wr) begin
                        next_req_addr = pwdata[ADDR_BITS-1:0];
                        next_req_erase = pwdata[REQ_ERASE_POS];
                        next_req_pending = 1'b1;
                    end
                end
                OFS_SCHEME: begin
                    next_prdata = {31'h0, per_sector_scheme};
                    if (apb_wr && !nv_config_locked) begin
                        next_scheme = pwdata[0];
                    end
                end
                default: begin
                    next_pslverr = 1'b1;
                end
            endcase
        end
        // Look up the sector being captured so its bits stand at decision
        guard_port.check_addr =
            next_req_addr[ADDR_BITS-1:ADDR_BITS-SECTOR_BITS];
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            status_one_volatile <= STATUS_RESET;
            status_one_nonvolatile <= STATUS_RESET;
            config_one_volatile <= CONFIG_RESET;
            config_one_nonvolatile <= CONFIG_RESET;
            guard_select <= '0;
            persistent_guard_lock_bit <= 1'b1;
            nv_config_locked <= 1'b0;
            per_sector_scheme <= 1'b0;
            req_pending <= 1'b0;
            req_erase <= 1'b0;
            req_addr <= '0;
            prdata <= 32'h0000_0000;
            pready <= 1'b0;
            pslverr <= 1'b0;
            request_granted <= 1'b0;
            request_refused <= 1'b0;
        end else begin
            status_one_volatile <= next_status_v;
            status_one_nonvolatile <= next_status_nv;
            config_one_volatile <= next_config_v;
            config_one_nonvolatile <= next_config_nv;
            guard_select <= next_guard_select;
            persistent_guard_lock_bit <= next_guard_lock;
            nv_config_locked <= next_nv_locked;
            per_sector_scheme <= next_scheme;
            req_pending <= next_req_pending;
            req_erase <= next_req_erase;
            req_addr <= next_req_addr;
            prdata <= next_prdata;
            pready <= next_pready;
            pslverr <= next_pslverr;
            request_granted <= next_granted;
            request_refused <= next_refused;
        end
    end
endmodule // fawp_top

// >>> bench/fawp_top_checker.sv
// Checker: bus and decision timing at the top-level ports
`timescale 1ns/1ps
module fawp_top_checker (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic request_granted,
    input wire logic request_refused
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    logic access;
    logic unmapped;
    logic req_now;
    assign access = psel && penable && !pready;
    assign unmapped = paddr[7:0] == 8'h20 || paddr[7:0] > 8'h24;
    assign req_now = access && pwrite && paddr[7:0] == 8'h1c;
    sequence req_taken; req_now; endsequence
    sequence answer_late; ##[2:4] (request_granted || request_refused);
    endsequence
    ready_wait_a: assert property (access |=> pready)
        else $error("pready late");
    ready_pulse_a: assert property (pready |=> !pready)
        else $error("pready too long");
    ready_cause_a: assert property (pready |-> $past(access))
        else $error("pready without access");
    error_unmapped_a: assert property (access && unmapped |=> pslverr)
        else $error("no pslverr");
    error_mapped_a: assert property (access && !unmapped |=> !pslverr)
        else $error("spurious pslverr");
    error_zero_a: assert property (pslverr |-> pready && prdata == 0)
        else $error("bad error response");
    answer_single_a: assert property (!(request_granted && request_refused))
        else $error("both answers");
    answer_due_a: assert property (req_taken |-> answer_late)
        else $error("request unanswered");
    answer_cause_a: assert property ((request_granted || request_refused)
        |-> $past(req_now, 2) || $past(req_now, 3) || $past(req_now, 4))
        else $error("answer without request");
endmodule // fawp_top_checker
bind fawp_top fawp_top_checker chk (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .request_granted(request_granted), .request_refused(request_refused));

// >>> bench/fawp_host.sv
// Host model: bus master issuing register and request transfers
`timescale 1ns/1ps
module fawp_host (
    input wire logic pclk,
    output logic psel,
    output logic penable,
    output logic pwrite,
    output logic [31:0] paddr,
    output logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr
);
    int gap = 0;
    initial begin
        {psel, penable, pwrite, paddr, pwdata} = '0;
    end
    // Request held until pready; released lines show inverted values
    task automatic xfer(input logic w, input logic [31:0] a,
        input logic [31:0] d, output logic [31:0] rd, output logic err);
        int n;
        repeat (gap + 1) @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        for (n = 0; n < 20; n++) begin
            @(posedge pclk);
            if (pready === 1'b1) break;
        end
        if (n == 20) fawp_top_tb.hang();
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        paddr <= ~a;
        pwdata <= ~d;
    endtask
endmodule // fawp_host

// >>> bench/fawp_top_tb.sv
// Testbench: register and request sequences with expected outcomes
`timescale 1ns/1ps
module fawp_top_tb;
    import fawp_pkg::*;
    logic pclk = 0, presetn = 0, wp_n = 1, err, psel, penable, pwrite;
    logic pready, pslverr, granted, refused;
    logic [31:0] paddr, pwdata, prdata, rd;
    int miscompares = 0, checks = 0, kb, lo;
    always #5 pclk = ~pclk;
    fawp_host host (.pclk(pclk), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr));
    fawp_top uut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .write_protect_input_n(wp_n), .request_granted(granted),
        .request_refused(refused));
    task complete_run;
        if (miscompares == 0 && checks > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    task hang;
        miscompares++;
        complete_run();
    endtask
    task check(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task wr(input logic [7:0] a, input logic [31:0] d);
        host.xfer(1'b1, {24'h0, a}, d, rd, err);
    endtask
    task wwe(input logic [7:0] a, input logic [31:0] d);
        wr(OFS_COMMAND, 32'h1);
        wr(a, d);
    endtask
    task expect_reg(input logic [7:0] a, input logic [31:0] exp);
        host.xfer(1'b0, {24'h0, a}, 32'h0, rd, err);
        check(rd, exp);
    endtask
    // Each request waits for its single answer before the next
    task req(input logic [24:0] a, input logic we, input logic grant);
        int n;
        if (we) wr(OFS_COMMAND, 32'h1);
        wr(OFS_REQUEST, {7'h0, a});
        for (n = 0; n < 8 && granted !== 1'b1 && refused !== 1'b1; n++)
            @(negedge pclk);
        if (n == 8) hang();
        check(32'(granted), 32'(grant));
        check(32'(refused), 32'(!grant));
    endtask
    initial begin
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        expect_reg(OFS_STATUS_ONE_V, 32'h0);
        expect_reg(OFS_COMMAND, 32'h1);
        check(32'(err), 32'h0);
        host.xfer(1'b0, 32'h20, 32'h0, rd, err);
        check({rd[30:0], err}, 32'h1);
        wr(OFS_STATUS_ONE_V, 32'h04);
        expect_reg(OFS_STATUS_ONE_V, 32'h0);
        // --------------------------------------------------------
        // Every level from both ends, probing both sides of the region edge where it lies inside the array
        // --------------------------------------------------------
        for (int t = 0; t < 2; t++)
            for (int l = 0; l < 8; l++) begin
                kb = (l == 0) ? 0 : ARRAY_KB >> (7 - l);
                lo = t ? 0 : ARRAY_KB - kb;
                wwe(OFS_CONFIG_ONE_V, 32'(t) << TOP_BOTTOM_POS);
                wwe(OFS_STATUS_ONE_V, 32'(l) << LEVEL_LSB);
                expect_reg(OFS_STATUS_ONE_V, 32'(l) << LEVEL_LSB);
                if (kb > 0)
                    req(25'(t ? kb * 1024 - 1 : lo * 1024), 1, 0);
                if (kb < ARRAY_KB)
                    req(25'(t ? kb * 1024 : lo * 1024 - 1), 1, 1);
            end
        wwe(OFS_CONFIG_ONE_V, 32'h0);
        wwe(OFS_STATUS_ONE_V, 32'h84);
        wp_n <= 1'b0;
        wwe(OFS_STATUS_ONE_V, 32'h0);
        expect_reg(OFS_STATUS_ONE_V, 32'h86);
        wwe(OFS_CONFIG_ONE_V, 32'h20);
        expect_reg(OFS_CONFIG_ONE_V, 32'h0);
        wp_n <= 1'b1;
        wwe(OFS_CONFIG_ONE_V, 32'h01);
        wwe(OFS_STATUS_ONE_V, 32'h0);
        expect_reg(OFS_STATUS_ONE_V, 32'h04);
        req(25'h1ffffff, 1, 0);
        wr(OFS_COMMAND, 32'h7);
        expect_reg(OFS_CONFIG_ONE_V, 32'h0);
        // --------------------------------------------------------
        // Per-sector guards on sector five
        // --------------------------------------------------------
        wr(OFS_SCHEME, 32'h1);
        wr(OFS_GUARD_SELECT, 32'h5);
        wwe(OFS_COMMAND, 32'h3);
        expect_reg(OFS_GUARD_DATA, 32'h2);
        req(25'(5 << 18), 1, 0);
        req(25'(6 << 18), 1, 1);
        wwe(OFS_COMMAND, 32'h103);
        req(25'(5 << 18), 1, 1);
        wwe(OFS_COMMAND, 32'h4);
        expect_reg(OFS_GUARD_DATA, 32'h1);
        req(25'(5 << 18), 1, 0);
        wr(OFS_COMMAND, 32'h6);
        expect_reg(OFS_COMMAND, 32'h0);
        wwe(OFS_COMMAND, 32'h5);
        expect_reg(OFS_GUARD_DATA, 32'h1);
        wr(OFS_COMMAND, 32'h2);
        req(25'(6 << 18), 0, 0);
        host.gap = 2;
        wwe(OFS_CONFIG_ONE_V, 32'h10);
        wwe(OFS_CONFIG_ONE_V, 32'h20);
        expect_reg(OFS_CONFIG_ONE_V, 32'h10);
        wr(OFS_COMMAND, 32'h8);
        expect_reg(OFS_COMMAND, 32'h2);
        wr(OFS_SCHEME, 32'h0);
        expect_reg(OFS_SCHEME, 32'h1);
        complete_run();
    end
endmodule // fawp_top_tb
